// ---- rtl/mcudec_core.sv ----
`timescale 1ns/1ps
`include "mcudec_defs.svh"
// Summary of operation
// - Fifty-nine functions sorted into five groups
// - Register/memory takes register plus memory operand
// - Loads, stores, arithmetic, logic, compares, bit test
// - Read-modify-write writes back; test does not
// - Inc, dec, clear, complement, negate, shifts, rotates, test
// - Branches are two bytes; false means no-op
// - Sixteen branch conditions plus branch-to-subroutine
// - Transfers, carry/mask control, interrupts, returns, stack, nop
// - Bit set/clear/test on lowest 256 bytes
// - Bit number lives in opcode bits three..one
// - Tested bit copied into carry always
// - Exactly ten addressing modes decoded
// - Indexed-no-offset one byte; longest three bytes
// - Literal operand is byte after opcode
// - Direct address is byte after opcode
// - Two-byte address from following two bytes
// - Signed offset added only when condition true
// - Upper nibble picks group and mode, except opcode AD and the empty cells
// - Index-only address is index register value
// - Byte offset plus index, unsigned sum
// - Word offset plus index, unsigned sum
// - Bit-branch: direct address, then signed offset
module mcudec_core (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Program byte stream
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic [15:0] byte_pc,
   // Datapath context
   input wire logic [7:0] index_reg,
   input wire logic [3:0] cc_flags,
   input wire logic irq_line,
   input wire logic [7:0] tested_byte,
   // Decoded instruction
   output logic dec_valid,
   output logic [7:0] dec_opcode,
   output mcudec_pkg::mcudec_group_t dec_group,
   output mcudec_pkg::mcudec_mode_t dec_mode,
   output mcudec_pkg::mcudec_op_t dec_op,
   output logic [1:0] dec_length,
   output logic dec_write_back,
   output logic dec_use_index,
   output logic dec_illegal,
   output logic [2:0] dec_bit_num,
   output logic [7:0] dec_literal,
   output logic [15:0] dec_eff_addr,
   output logic dec_eff_addr_valid,
   // Branch resolution
   output logic branch_taken,
   output logic [15:0] branch_target,
   output logic carry_load,
   output logic carry_value
);
   // All module state in one record
   typedef struct packed {
      mcudec_pkg::mcudec_state_t st;
      logic [7:0] opcode;
      logic [7:0] b2;
      logic [15:0] pc0;
      mcudec_pkg::mcudec_group_t group;
      mcudec_pkg::mcudec_mode_t mode;
      mcudec_pkg::mcudec_op_t op;
      logic [1:0] length;
      logic wb;
      logic uix;
      logic ill;
      logic valid;
      logic [7:0] literal;
      logic [15:0] ea;
      logic ea_valid;
      logic taken;
      logic [15:0] target;
      logic cload;
      logic cval;
   } mcudec_core_state_t;

   mcudec_core_state_t r;
   mcudec_core_state_t next_r;

   // Classifier for the byte presented in opcode position
   mcudec_pkg::mcudec_group_t t_group;
   mcudec_pkg::mcudec_mode_t t_mode;
   mcudec_pkg::mcudec_op_t t_op;
   logic [1:0] t_length;
   logic t_wb;
   logic t_uix;
   logic t_ill;

   mcudec_table u_table (
      .opcode(byte_data),
      .group(t_group),
      .mode(t_mode),
      .op(t_op),
      .length(t_length),
      .writes_back(t_wb),
      .use_index(t_uix),
      .illegal(t_ill)
   );

   // Branch condition of the relative row, low nibble selects; odd codes invert
   function automatic logic cond_true(input logic [3:0] sel, input logic [3:0] f, input logic irq);
      logic base;
      base = 1'b0;
      unique case (sel[3:1])
         3'h0: base = 1'b1;
         3'h1: base = ~(f[`MCUDEC_FLAG_C] | f[`MCUDEC_FLAG_Z]);
         3'h2: base = ~f[`MCUDEC_FLAG_C];
         3'h3: base = ~f[`MCUDEC_FLAG_Z];
         3'h4: base = ~f[`MCUDEC_FLAG_H];
         3'h5: base = ~f[`MCUDEC_FLAG_N];
         3'h6: base = 1'b1; // No mask input: mask reads clear
         default: base = ~irq;
      endcase
      return sel[0] ? ~base : base;
   endfunction

   // Signed offset added to the address after the instruction
   function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [1:0] len, input logic [7:0] off);
      return 16'(pc + {14'h0000, len} + {{8{off[7]}}, off});
   endfunction

   // Next-state: collect bytes, then resolve the instruction
   always_comb begin
      logic [15:0] ea;
      logic cond;
      logic bit_val;
      ea = `MCUDEC_RST_ADDR;
      cond = 1'b0;
      bit_val = 1'b0;
      next_r = r;
      next_r.valid = 1'b0;
      next_r.cload = 1'b0;
      next_r.taken = 1'b0;
      if (byte_valid) begin
         unique case (r.st)
            mcudec_pkg::MCUDEC_ST_OPCODE: begin
               next_r.opcode = byte_data;
               next_r.pc0 = byte_pc;
               next_r.group = t_group;
               next_r.mode = t_mode;
               next_r.op = t_op;
               next_r.length = t_length;
               next_r.wb = t_wb;
               next_r.uix = t_uix;
               next_r.ill = t_ill;
               if (t_length == 2'd1) begin
                  // Single-byte: inherent or index with no offset
                  next_r.valid = 1'b1;
                  next_r.ea_valid = (t_mode == mcudec_pkg::MCUDEC_AM_INDEX_NONE);
                  next_r.ea = {8'h00, index_reg};
                  next_r.literal = `MCUDEC_RST_BYTE;
               end else begin
                  next_r.st = mcudec_pkg::MCUDEC_ST_BYTE2;
               end
            end
            mcudec_pkg::MCUDEC_ST_BYTE2: begin
               next_r.b2 = byte_data;
               if (r.length == 2'd3) begin
                  next_r.st = mcudec_pkg::MCUDEC_ST_BYTE3;
               end else begin
                  next_r.st = mcudec_pkg::MCUDEC_ST_OPCODE;
                  next_r.valid = 1'b1;
                  next_r.literal = byte_data;
                  next_r.ea_valid = 1'b1;
                  unique case (r.mode)
                     mcudec_pkg::MCUDEC_AM_INDEX_BYTE: ea = 16'({8'h00, index_reg} + {8'h00, byte_data});
                     mcudec_pkg::MCUDEC_AM_PC_OFFSET: begin
                        cond = (r.op == mcudec_pkg::MCUDEC_OP_BSUB) ? 1'b1
                             : cond_true(r.opcode[3:0], cc_flags, irq_line);
                        ea = rel_target(r.pc0, r.length, byte_data);
                        next_r.taken = cond;
                     end
                     mcudec_pkg::MCUDEC_AM_LITERAL: next_r.ea_valid = 1'b0;
                     default: ea = {8'h00, byte_data};
                  endcase
                  next_r.ea = ea;
                  next_r.target = cond ? ea : 16'(r.pc0 + {14'h0000, r.length});
               end
            end
            default: begin
               next_r.st = mcudec_pkg::MCUDEC_ST_OPCODE;
               next_r.valid = 1'b1;
               next_r.ea_valid = 1'b1;
               next_r.literal = byte_data;
               unique case (r.mode)
                  mcudec_pkg::MCUDEC_AM_BIT_TEST_BRANCH: begin
                     // Tested byte read from direct address in byte two
                     bit_val = tested_byte[r.opcode[3:1]];
                     cond = r.opcode[0] ? ~bit_val : bit_val;
                     next_r.ea = {8'h00, r.b2};
                     next_r.cload = 1'b1;
                     next_r.cval = bit_val;
                     next_r.taken = cond;
                     next_r.target = rel_target(r.pc0, r.length, cond ? byte_data : 8'h00);
                  end
                  mcudec_pkg::MCUDEC_AM_INDEX_WORD:
                     next_r.ea = 16'({r.b2, byte_data} + {8'h00, index_reg});
                  default: next_r.ea = {r.b2, byte_data};
               endcase
            end
         endcase
      end
   end

   // Register the whole state
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign dec_valid = r.valid;
   assign dec_opcode = r.opcode;
   assign dec_group = r.group;
   assign dec_mode = r.mode;
   assign dec_op = r.op;
   assign dec_length = r.length;
   assign dec_write_back = r.wb;
   assign dec_use_index = r.uix;
   assign dec_illegal = r.ill;
   assign dec_bit_num = r.opcode[3:1];
   assign dec_literal = r.literal;
   assign dec_eff_addr = r.ea;
   assign dec_eff_addr_valid = r.ea_valid;
   assign branch_taken = r.taken;
   assign branch_target = r.target;
   assign carry_load = r.cload;
   assign carry_value = r.cval;
endmodule // mcudec_core

// ---- rtl/mcudec_defs.svh ----
`ifndef MCUDEC_DEFS_SVH
`define MCUDEC_DEFS_SVH
// Opcode upper nibble values
`define MCUDEC_HI_BITBR 4'h0
`define MCUDEC_HI_BITSC 4'h1
`define MCUDEC_HI_PCOFF 4'h2
`define MCUDEC_HI_RMW_DIR 4'h3
`define MCUDEC_HI_RMW_A 4'h4
`define MCUDEC_HI_RMW_X 4'h5
`define MCUDEC_HI_RMW_XB 4'h6
`define MCUDEC_HI_RMW_XN 4'h7
`define MCUDEC_HI_CTL_8 4'h8
`define MCUDEC_HI_CTL_9 4'h9
`define MCUDEC_HI_LIT 4'hA
`define MCUDEC_HI_DIR 4'hB
`define MCUDEC_HI_ABS 4'hC
`define MCUDEC_HI_XW 4'hD
`define MCUDEC_HI_XB 4'hE
`define MCUDEC_HI_XN 4'hF
// Special opcodes
`define MCUDEC_OP_SUBBR 8'hAD
// Reset value of decoded outputs
`define MCUDEC_RST_BYTE 8'h00
`define MCUDEC_RST_ADDR 16'h0000
// Flag positions in cc_flags {H,N,Z,C}
`define MCUDEC_FLAG_C 0
`define MCUDEC_FLAG_Z 1
`define MCUDEC_FLAG_N 2
`define MCUDEC_FLAG_H 3
`endif

// ---- rtl/mcudec_pkg.sv ----
package mcudec_pkg;
   // Instruction groups
   typedef enum logic [2:0] {
      MCUDEC_GRP_REGMEM = 3'h0,
      MCUDEC_GRP_RMW = 3'h1,
      MCUDEC_GRP_BRANCH = 3'h2,
      MCUDEC_GRP_BIT = 3'h3,
      MCUDEC_GRP_CONTROL = 3'h4
   } mcudec_group_t;
   // The ten addressing modes
   typedef enum logic [3:0] {
      MCUDEC_AM_IMPLIED = 4'h0,
      MCUDEC_AM_LITERAL = 4'h1,
      MCUDEC_AM_DIRECT = 4'h2,
      MCUDEC_AM_TWO_BYTE = 4'h3,
      MCUDEC_AM_PC_OFFSET = 4'h4,
      MCUDEC_AM_INDEX_NONE = 4'h5,
      MCUDEC_AM_INDEX_BYTE = 4'h6,
      MCUDEC_AM_INDEX_WORD = 4'h7,
      MCUDEC_AM_BIT_SET_CLEAR = 4'h8,
      MCUDEC_AM_BIT_TEST_BRANCH = 4'h9
   } mcudec_mode_t;
   // Operations (59 basic functions, plus one harmless fallback)
   typedef enum logic [5:0] {
      MCUDEC_OP_NOP = 6'h00, MCUDEC_OP_LDA = 6'h01, MCUDEC_OP_LDX = 6'h02, MCUDEC_OP_STA = 6'h03,
      MCUDEC_OP_STX = 6'h04, MCUDEC_OP_ADD = 6'h05, MCUDEC_OP_ADC = 6'h06, MCUDEC_OP_SUB = 6'h07,
      MCUDEC_OP_SBC = 6'h08, MCUDEC_OP_AND = 6'h09, MCUDEC_OP_ORA = 6'h0A, MCUDEC_OP_EOR = 6'h0B,
      MCUDEC_OP_CMP = 6'h0C, MCUDEC_OP_CPX = 6'h0D, MCUDEC_OP_BITTEST = 6'h0E, MCUDEC_OP_JUMP = 6'h0F,
      MCUDEC_OP_JSUB = 6'h10, MCUDEC_OP_INC = 6'h11, MCUDEC_OP_DEC = 6'h12, MCUDEC_OP_CLR = 6'h13,
      MCUDEC_OP_COM = 6'h14, MCUDEC_OP_NEG = 6'h15, MCUDEC_OP_ROL = 6'h16, MCUDEC_OP_ROR = 6'h17,
      MCUDEC_OP_LSL = 6'h18, MCUDEC_OP_LSR = 6'h19, MCUDEC_OP_ASR = 6'h1A, MCUDEC_OP_TESTNZ = 6'h1B,
      MCUDEC_OP_BRANCH = 6'h1C, MCUDEC_OP_BSUB = 6'h1D, MCUDEC_OP_TAX = 6'h1E, MCUDEC_OP_TXA = 6'h1F,
      MCUDEC_OP_SEC = 6'h20, MCUDEC_OP_CLC = 6'h21, MCUDEC_OP_SEI = 6'h22, MCUDEC_OP_CLI = 6'h23,
      MCUDEC_OP_SWI = 6'h24, MCUDEC_OP_RTS = 6'h25, MCUDEC_OP_RTI = 6'h26, MCUDEC_OP_RSP = 6'h27,
      MCUDEC_OP_BSETB = 6'h28, MCUDEC_OP_BCLRB = 6'h29, MCUDEC_OP_BRSETB = 6'h2A, MCUDEC_OP_BRCLRB = 6'h2B
   } mcudec_op_t;
   // Fetch sequencer states
   typedef enum logic [1:0] {
      MCUDEC_ST_OPCODE = 2'h0,
      MCUDEC_ST_BYTE2 = 2'h1,
      MCUDEC_ST_BYTE3 = 2'h2
   } mcudec_state_t;
endpackage

// ---- rtl/mcudec_table.sv ----
`timescale 1ns/1ps
`include "mcudec_defs.svh"
// Combinational opcode classifier, registered by the caller
module mcudec_table (
   // Opcode in
   input wire logic [7:0] opcode,
   // Classification out
   output mcudec_pkg::mcudec_group_t group,
   output mcudec_pkg::mcudec_mode_t mode,
   output mcudec_pkg::mcudec_op_t op,
   output logic [1:0] length,
   output logic writes_back,
   output logic use_index,
   output logic illegal
);
   logic [3:0] hi;
   logic [3:0] lo;
   assign hi = opcode[7:4];
   assign lo = opcode[3:0];

   // Group, mode and operation from the nibbles
   always_comb begin
      group = mcudec_pkg::MCUDEC_GRP_CONTROL;
      mode = mcudec_pkg::MCUDEC_AM_IMPLIED;
      op = mcudec_pkg::MCUDEC_OP_NOP;
      writes_back = 1'b0;
      use_index = 1'b0;
      illegal = 1'b0;
      unique case (hi)
         `MCUDEC_HI_BITBR: begin
            group = mcudec_pkg::MCUDEC_GRP_BIT;
            mode = mcudec_pkg::MCUDEC_AM_BIT_TEST_BRANCH;
            op = lo[0] ? mcudec_pkg::MCUDEC_OP_BRCLRB : mcudec_pkg::MCUDEC_OP_BRSETB;
         end
         `MCUDEC_HI_BITSC: begin
            group = mcudec_pkg::MCUDEC_GRP_BIT;
            mode = mcudec_pkg::MCUDEC_AM_BIT_SET_CLEAR;
            op = lo[0] ? mcudec_pkg::MCUDEC_OP_BCLRB : mcudec_pkg::MCUDEC_OP_BSETB;
            writes_back = 1'b1;
         end
         `MCUDEC_HI_PCOFF: begin
            group = mcudec_pkg::MCUDEC_GRP_BRANCH;
            mode = mcudec_pkg::MCUDEC_AM_PC_OFFSET;
            op = mcudec_pkg::MCUDEC_OP_BRANCH;
         end
         `MCUDEC_HI_RMW_DIR, `MCUDEC_HI_RMW_A, `MCUDEC_HI_RMW_X, `MCUDEC_HI_RMW_XB, `MCUDEC_HI_RMW_XN: begin
            group = mcudec_pkg::MCUDEC_GRP_RMW;
            unique case (hi)
               `MCUDEC_HI_RMW_DIR: mode = mcudec_pkg::MCUDEC_AM_DIRECT;
               `MCUDEC_HI_RMW_XB: mode = mcudec_pkg::MCUDEC_AM_INDEX_BYTE;
               `MCUDEC_HI_RMW_XN: mode = mcudec_pkg::MCUDEC_AM_INDEX_NONE;
               default: mode = mcudec_pkg::MCUDEC_AM_IMPLIED;
            endcase
            use_index = (hi == `MCUDEC_HI_RMW_X);
            writes_back = 1'b1;
            unique case (lo)
               4'h0: op = mcudec_pkg::MCUDEC_OP_NEG;
               4'h3: op = mcudec_pkg::MCUDEC_OP_COM;
               4'h4: op = mcudec_pkg::MCUDEC_OP_LSR;
               4'h6: op = mcudec_pkg::MCUDEC_OP_ROR;
               4'h7: op = mcudec_pkg::MCUDEC_OP_ASR;
               4'h8: op = mcudec_pkg::MCUDEC_OP_LSL;
               4'h9: op = mcudec_pkg::MCUDEC_OP_ROL;
               4'hA: op = mcudec_pkg::MCUDEC_OP_DEC;
               4'hC: op = mcudec_pkg::MCUDEC_OP_INC;
               4'hD: begin
                  op = mcudec_pkg::MCUDEC_OP_TESTNZ;
                  writes_back = 1'b0;
               end
               4'hF: op = mcudec_pkg::MCUDEC_OP_CLR;
               default: begin
                  // Empty cell: harmless no-operation, one byte
                  group = mcudec_pkg::MCUDEC_GRP_CONTROL;
                  mode = mcudec_pkg::MCUDEC_AM_IMPLIED;
                  writes_back = 1'b0;
                  use_index = 1'b0;
                  illegal = 1'b1;
               end
            endcase
         end
         `MCUDEC_HI_CTL_8, `MCUDEC_HI_CTL_9: begin
            group = mcudec_pkg::MCUDEC_GRP_CONTROL;
            unique case (opcode)
               8'h80: op = mcudec_pkg::MCUDEC_OP_RTI;
               8'h81: op = mcudec_pkg::MCUDEC_OP_RTS;
               8'h83: op = mcudec_pkg::MCUDEC_OP_SWI;
               8'h97: op = mcudec_pkg::MCUDEC_OP_TAX;
               8'h98: op = mcudec_pkg::MCUDEC_OP_CLC;
               8'h99: op = mcudec_pkg::MCUDEC_OP_SEC;
               8'h9A: op = mcudec_pkg::MCUDEC_OP_CLI;
               8'h9B: op = mcudec_pkg::MCUDEC_OP_SEI;
               8'h9C: op = mcudec_pkg::MCUDEC_OP_RSP;
               8'h9D: op = mcudec_pkg::MCUDEC_OP_NOP;
               8'h9F: op = mcudec_pkg::MCUDEC_OP_TXA;
               default: illegal = 1'b1;
            endcase
         end
         default: begin
            // Register/memory columns, one operand from memory
            group = mcudec_pkg::MCUDEC_GRP_REGMEM;
            unique case (hi)
               `MCUDEC_HI_LIT: mode = mcudec_pkg::MCUDEC_AM_LITERAL;
               `MCUDEC_HI_DIR: mode = mcudec_pkg::MCUDEC_AM_DIRECT;
               `MCUDEC_HI_ABS: mode = mcudec_pkg::MCUDEC_AM_TWO_BYTE;
               `MCUDEC_HI_XW: mode = mcudec_pkg::MCUDEC_AM_INDEX_WORD;
               `MCUDEC_HI_XB: mode = mcudec_pkg::MCUDEC_AM_INDEX_BYTE;
               default: mode = mcudec_pkg::MCUDEC_AM_INDEX_NONE;
            endcase
            unique case (lo)
               4'h0: op = mcudec_pkg::MCUDEC_OP_SUB;
               4'h1: op = mcudec_pkg::MCUDEC_OP_CMP;
               4'h2: op = mcudec_pkg::MCUDEC_OP_SBC;
               4'h3: op = mcudec_pkg::MCUDEC_OP_CPX;
               4'h4: op = mcudec_pkg::MCUDEC_OP_AND;
               4'h5: op = mcudec_pkg::MCUDEC_OP_BITTEST;
               4'h6: op = mcudec_pkg::MCUDEC_OP_LDA;
               4'h7: op = mcudec_pkg::MCUDEC_OP_STA;
               4'h8: op = mcudec_pkg::MCUDEC_OP_EOR;
               4'h9: op = mcudec_pkg::MCUDEC_OP_ADC;
               4'hA: op = mcudec_pkg::MCUDEC_OP_ORA;
               4'hB: op = mcudec_pkg::MCUDEC_OP_ADD;
               4'hC: op = mcudec_pkg::MCUDEC_OP_JUMP;
               4'hD: op = mcudec_pkg::MCUDEC_OP_JSUB;
               4'hE: op = mcudec_pkg::MCUDEC_OP_LDX;
               default: op = mcudec_pkg::MCUDEC_OP_STX;
            endcase
            // Store or jump with a literal operand makes no sense
            if (hi == `MCUDEC_HI_LIT && (lo == 4'h7 || lo == 4'hC || lo == 4'hF)) begin
               group = mcudec_pkg::MCUDEC_GRP_CONTROL;
               mode = mcudec_pkg::MCUDEC_AM_IMPLIED;
               op = mcudec_pkg::MCUDEC_OP_NOP;
               illegal = 1'b1;
            end
            if (opcode == `MCUDEC_OP_SUBBR) begin
               group = mcudec_pkg::MCUDEC_GRP_BRANCH;
               mode = mcudec_pkg::MCUDEC_AM_PC_OFFSET;
               op = mcudec_pkg::MCUDEC_OP_BSUB;
               illegal = 1'b0;
            end
         end
      endcase
   end

   // Instruction length follows the mode
   always_comb begin
      unique case (mode)
         mcudec_pkg::MCUDEC_AM_IMPLIED, mcudec_pkg::MCUDEC_AM_INDEX_NONE: length = 2'd1;
         mcudec_pkg::MCUDEC_AM_TWO_BYTE, mcudec_pkg::MCUDEC_AM_INDEX_WORD,
         mcudec_pkg::MCUDEC_AM_BIT_TEST_BRANCH: length = 2'd3;
         default: length = 2'd2;
      endcase
   end
endmodule // mcudec_table

// ---- tb/mcudec_sva.sv ----
`timescale 1ns/1ps
// Port checks on the decoded instruction stream
module mcudec_sva (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Datapath context
   input wire logic [7:0] tested_byte,
   // Decoded instruction
   input wire logic dec_valid,
   input wire logic [7:0] dec_opcode,
   input mcudec_pkg::mcudec_group_t dec_group,
   input mcudec_pkg::mcudec_mode_t dec_mode,
   input mcudec_pkg::mcudec_op_t dec_op,
   input wire logic [1:0] dec_length,
   input wire logic dec_write_back,
   input wire logic dec_illegal,
   input wire logic [2:0] dec_bit_num,
   input wire logic [15:0] dec_eff_addr,
   // Branch resolution
   input wire logic branch_taken,
   input wire logic carry_load,
   input wire logic carry_value
);
   logic [7:0] tested_q; // Memory byte as seen at the final byte
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Keep the tested byte one cycle, since the answer lags the last byte
   always_ff @(posedge clock) begin
      tested_q <= tested_byte;
   end
   // Completed decodes by kind
   sequence s_btb; dec_valid && dec_mode == mcudec_pkg::MCUDEC_AM_BIT_TEST_BRANCH; endsequence
   sequence s_ixn; dec_valid && dec_mode == mcudec_pkg::MCUDEC_AM_INDEX_NONE; endsequence
   sequence s_bad; dec_valid && dec_illegal; endsequence
   property p_btb_carry; s_btb |-> carry_load && carry_value == tested_q[dec_bit_num]; endproperty
   a_btb_carry: assert property (p_btb_carry) else $error("carry copy wrong");
   property p_btb_take; s_btb |-> branch_taken == (carry_value ^ dec_opcode[0]); endproperty
   a_btb_take: assert property (p_btb_take) else $error("bit branch wrong");
   property p_carry_only; carry_load |-> s_btb; endproperty
   a_carry_only: assert property (p_carry_only) else $error("stray carry load");
   property p_carry_pulse; carry_load |=> !carry_load [*2]; endproperty
   a_carry_pulse: assert property (p_carry_pulse) else $error("carry load too long");
   property p_btb_shape;
      s_btb |-> dec_length == 2'h3 && dec_group == mcudec_pkg::MCUDEC_GRP_BIT && dec_bit_num == dec_opcode[3:1];
   endproperty
   a_btb_shape: assert property (p_btb_shape) else $error("bit branch shape");
   property p_ix_shape; s_ixn |-> dec_length == 2'h1 && dec_eff_addr[15:8] == 8'h00; endproperty
   a_ix_shape: assert property (p_ix_shape) else $error("index form wrong");
   property p_illegal; s_bad |-> dec_op == mcudec_pkg::MCUDEC_OP_NOP && dec_length == 2'h1 && !branch_taken; endproperty
   a_illegal: assert property (p_illegal) else $error("empty cell not nop");
   property p_rmw_wb;
      dec_valid && !dec_illegal && dec_group == mcudec_pkg::MCUDEC_GRP_RMW |->
         dec_write_back == (dec_op != mcudec_pkg::MCUDEC_OP_TESTNZ);
   endproperty
   a_rmw_wb: assert property (p_rmw_wb) else $error("write back wrong");
endmodule // mcudec_sva
bind mcudec_core mcudec_sva i_sva (.clock, .rst_n, .tested_byte, .dec_valid, .dec_opcode, .dec_group,
   .dec_mode, .dec_op, .dec_length, .dec_write_back, .dec_illegal, .dec_bit_num, .dec_eff_addr,
   .branch_taken, .carry_load, .carry_value);

// ---- tb/mcudec_prog_mem.sv ----
`timescale 1ns/1ps
// Program memory feeding opcode and operand bytes
module mcudec_prog_mem (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Fetch request
   input wire logic start,
   input wire logic [7:0] start_pc,
   input wire logic [1:0] count,
   input wire logic slow,
   // Byte stream
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic [15:0] byte_pc
);
   logic [7:0] mem [0:255]; // Program bytes, loaded by the bench
   logic [7:0] addr; // Next fetch address
   logic [1:0] left; // Bytes still to send
   logic gap; // Slow mode idles one cycle per byte
   // Idle bus inverts, so a stale byte never passes for a fresh one
   always @(posedge clock) begin
      byte_valid <= 1'b0;
      byte_data <= ~byte_data;
      byte_pc <= ~byte_pc;
      gap <= 1'b0;
      if (!rst_n) begin
         left <= 2'h0;
         byte_data <= 8'h00;
         byte_pc <= 16'h0000;
      end else if (start) begin
         addr <= start_pc;
         left <= count;
      end else if (left != 2'h0) begin
         if (slow && !gap) begin
            gap <= 1'b1;
         end else begin
            byte_valid <= 1'b1;
            byte_data <= mem[addr];
            byte_pc <= {8'h00, addr};
            addr <= addr + 8'h01;
            left <= left - 2'h1;
         end
      end
   end
endmodule // mcudec_prog_mem

// ---- tb/mcudec_core_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the instruction decoder
module mcudec_core_tb;
   logic clock, rst_n, start, slow, byte_valid, irq_line;
   logic [7:0] start_pc, byte_data, index_reg, tested_byte;
   logic [1:0] count;
   logic [15:0] byte_pc;
   logic [3:0] cc_flags;
   logic dec_valid, dec_write_back, dec_use_index, dec_illegal, dec_eff_addr_valid;
   logic branch_taken, carry_load, carry_value;
   logic [7:0] dec_opcode, dec_literal;
   logic [2:0] dec_bit_num;
   logic [1:0] dec_length;
   logic [15:0] dec_eff_addr, branch_target;
   mcudec_pkg::mcudec_group_t dec_group;
   mcudec_pkg::mcudec_mode_t dec_mode;
   mcudec_pkg::mcudec_op_t dec_op;
   int errors, comparisons;
   mcudec_prog_mem i_mem (.*);
   mcudec_core i_dut (.*);
   // 250 MHz core clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // Compare and tally
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task complete_run;
      if (errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Load code, set context {irq,H,N,Z,C}, fetch, await the decode pulse
   task automatic run(input logic [7:0] pc, input logic [23:0] code, input logic [1:0] n, input logic s = 1'b0,
      input logic [7:0] x = 8'h20, input logic [4:0] f = 5'h00, input logic [7:0] t = 8'h00);
      i_mem.mem[pc] = code[23:16];
      i_mem.mem[pc + 8'h01] = code[15:8];
      i_mem.mem[pc + 8'h02] = code[7:0];
      @(posedge clock);
      start <= 1'b1;
      start_pc <= pc;
      count <= n;
      slow <= s;
      index_reg <= x;
      cc_flags <= f[3:0];
      irq_line <= f[4];
      tested_byte <= t;
      @(posedge clock);
      start <= 1'b0;
      for (int k = 0; k < 12 && dec_valid !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      check(dec_valid, 1'b1);
   endtask
   // Branch condition from flags {irq,H,N,Z,C}; mask flag reads clear
   function automatic logic cond(input logic [3:0] c, input logic [4:0] f);
      logic [7:0] base;
      base = {!f[4], 1'b1, !f[2], !f[3], !f[1], !f[0], !(f[0] | f[1]), 1'b1};
      return base[c[3:1]] ^ c[0];
   endfunction
   // Register/memory addressing modes
   task t_modes;
      run(8'h10, 24'hC61234, 2'h3, 1'b1);
      check(dec_op, mcudec_pkg::MCUDEC_OP_LDA);
      check(dec_eff_addr, 16'h1234);
      run(8'h20, 24'hB6F000, 2'h2);
      check(dec_eff_addr, 16'h00F0);
      check(dec_eff_addr_valid, 1'b1);
      run(8'h28, 24'hA65A00, 2'h2);
      check(dec_literal, 8'h5A);
      check(dec_mode, mcudec_pkg::MCUDEC_AM_LITERAL);
      check(dec_eff_addr_valid, 1'b0);
      run(8'h30, 24'hE6F000, 2'h2, 1'b1);
      check(dec_eff_addr, 16'h0110);
      run(8'h38, 24'hDC12F0, 2'h3);
      check(dec_op, mcudec_pkg::MCUDEC_OP_JUMP);
      check(dec_eff_addr, 16'h1310);
      run(8'h3C, 24'hF60000, 2'h1, 1'b0, 8'h80);
      check(dec_eff_addr, 16'h0080);
      check(dec_length, 2'h1);
   endtask
   // Sixteen conditions, three flag sets, then subroutine branch
   task t_branch;
      logic [4:0] f;
      logic tk;
      for (int c = 0; c < 16; c++) begin
         for (int s = 0; s < 3; s++) begin
            f = (s == 0) ? 5'h00 : (s == 1) ? 5'h0A : 5'h15;
            run(8'h40, {4'h2, c[3:0], 16'hF000}, 2'h2, s[0], 8'h00, f, 8'h00);
            tk = cond(c[3:0], f);
            check(branch_taken, tk);
            check(branch_target, tk ? 16'h0032 : 16'h0042);
            check(dec_length, 2'h2);
         end
      end
      run(8'h40, 24'hAD1000, 2'h2);
      check(branch_target, 16'h0052);
   endtask
   // Every bit number, both polarities, test-branch and set/clear
   task t_bits;
      logic [7:0] pat;
      logic tk;
      pat = 8'hA5;
      for (int n = 0; n < 8; n++) begin
         for (int k = 0; k < 2; k++) begin
            run(8'h60, {4'h0, n[2:0], k[0], 16'h3508}, 2'h3, k[0], 8'h00, 5'h00, pat);
            tk = pat[n] ^ k[0];
            check(carry_value, pat[n]);
            check(branch_target, tk ? 16'h006B : 16'h0063);
            check(dec_bit_num, n[2:0]);
            check(dec_eff_addr, 16'h0035);
            check(dec_op, k ? mcudec_pkg::MCUDEC_OP_BRCLRB : mcudec_pkg::MCUDEC_OP_BRSETB);
            run(8'h70, {4'h1, n[2:0], k[0], 16'h3500}, 2'h2, 1'b0, 8'h00, 5'h00, pat);
            check(dec_mode, mcudec_pkg::MCUDEC_AM_BIT_SET_CLEAR);
            check(dec_op, k ? mcudec_pkg::MCUDEC_OP_BCLRB : mcudec_pkg::MCUDEC_OP_BSETB);
            check(dec_eff_addr, 16'h0035);
         end
      end
   endtask
   // Read-modify-write, control and an empty cell
   task t_rmw_ctl;
      run(8'h80, 24'h3A1000, 2'h2);
      check(dec_op, mcudec_pkg::MCUDEC_OP_DEC);
      check(dec_write_back, 1'b1);
      run(8'h84, 24'h7D0000, 2'h1);
      check(dec_op, mcudec_pkg::MCUDEC_OP_TESTNZ);
      check(dec_write_back, 1'b0);
      run(8'h88, 24'h970000, 2'h1);
      check(dec_group, mcudec_pkg::MCUDEC_GRP_CONTROL);
      run(8'h8C, 24'h310000, 2'h1);
      check(dec_op, mcudec_pkg::MCUDEC_OP_NOP);
      check(dec_illegal, 1'b1);
      run(8'h90, 24'h5C0000, 2'h1);
      check(dec_use_index, 1'b1);
   endtask
   // Hang guard, well beyond the expected run length
   initial begin
      #60000;
      errors++;
      complete_run();
   end
   // Reset, then the scenarios
   initial begin
      {rst_n, start, slow, irq_line, start_pc, count, index_reg, cc_flags, tested_byte} = '0;
      errors = 0;
      comparisons = 0;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      check(dec_valid, 1'b0);
      t_modes();
      t_branch();
      t_bits();
      t_rmw_ctl();
      complete_run();
   end
endmodule // mcudec_core_tb
